// [inc/vdsr_pkg.sv]
// Constants and carrier types for the video decoder status register bank
package vdsr_pkg;

  // Register sub addresses
  localparam logic [7:0] ADDR_REQUEST = 8'h0a;
  localparam logic [7:0] ADDR_STATUS = 8'h10;
  localparam logic [7:0] ADDR_COPY = 8'h11;
  localparam logic [7:0] ADDR_CAPTION_LOW = 8'h12;
  localparam logic [7:0] ADDR_CAPTION_HIGH = 8'h13;
  localparam logic [7:0] ADDR_EXTENDED_LOW = 8'h14;
  localparam logic [7:0] ADDR_EXTENDED_HIGH = 8'h15;
  localparam logic [7:0] ADDR_VBWSS_ONE = 8'h16;
  localparam logic [7:0] ADDR_VBWSS_TWO = 8'h17;
  localparam logic [7:0] ADDR_PART = 8'h18;

  // Decode request bit positions
  localparam int REQ_CAPTION_BIT = 0;
  localparam int REQ_EXTENDED_BIT = 1;
  localparam int REQ_VBWSS_BIT = 2;

  // Values after reset, and the value read at an unmapped address
  localparam logic [15:0] WORD_RESET = 16'h0000;
  localparam logic [7:0] READ_RESET = 8'h00;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;

  // Live levels from the video datapath
  typedef struct packed {
    logic gainMethodFlag;
    logic verticalLockFail;
    logic inputOverflowFlag;
    logic chromaSuppressActive;
    logic noInputFlag;
  } vdsr_video_t;

  // Copy-protection detector levels, msb first as read at bits 6..0
  typedef struct packed {
    logic fakeSyncFound;
    logic gainPulseFound;
    logic porchPulseFound;
    logic syncShrinkFound;
    logic stripeKind;
    logic stripeFound;
    logic cpGainProcessFound;
  } vdsr_copy_t;

  // Decode completion strobes and results
  typedef struct packed {
    logic captionDone;
    logic extendedDone;
    logic vbidWssDone;
    logic wssMode;
    logic [15:0] captionWord;
    logic [15:0] extendedWord;
    logic [13:0] vbidWssWord;
  } vdsr_done_t;

  // Decoders armed and waiting for data
  typedef struct packed {
    logic vbidWss;
    logic extended;
    logic caption;
  } vdsr_armed_t;

endpackage : vdsr_pkg

// [logic/vdsr_status_regs.sv]
// Read-only status and decoded-data register bank of the video decoder
//
// Notes on behaviour
// - Status bit 0 high when no input
// - Status bit 1 shows chroma suppression active
// - Status bit 2 shows converter input overflow
// - Status bit 3 high when vertical lock fails
// - Status bit 4 zero sync, one peak gain
// - Status bit 5 caption data held
// - Status bit 6 extended data held
// - Status bit 7 VBID or WSS held
// - Request write clears flag, arms, completion sets
// - Protection bit 0 gain process found
// - Protection bit 1 color stripe found
// - Protection bit 2 stripe type 2 or 3
// - Protection bit 3 sync amplitude reduced
// - Protection bit 4 back porch pulse
// - Protection bits 5,6 gain and fake sync
// - Caption word low 0x12, high 0x13
// - Extended word low 0x14, high 0x15
// - VBID bits placed across 0x16, 0x17
// - WSS bits placed ascending across 0x17, 0x16
// - Identity holds part code and revision
`timescale 1ns/10ps
module vdsr_status_regs
  import vdsr_pkg::*;
#(
  parameter logic [5:0] PART_CODE = 6'h15,     // Arbitrary value
  parameter logic [1:0] REVISION_NUMBER = 2'h1 // Arbitrary value
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic [7:0] regAddr,
  input wire logic regWrEn,
  input wire logic [7:0] regWrData,
  input wire logic regRdEn,
  output logic [7:0] regRdData,
  input wire vdsr_video_t videoStatus,
  input wire vdsr_copy_t copyStatus,
  input wire vdsr_done_t decodeDone,
  output vdsr_armed_t decodeArmed
);

  // Both VBID and WSS land in one 16-bit image: high byte 0x16, low byte 0x17
  function automatic logic [15:0] vbwssImage(input logic wss, input logic [13:0] w);
    logic [15:0] img;
    img = 16'h0000;
    if (wss) begin
      img[7:0] = w[7:0];
      img[13:8] = w[13:8];
    end else begin
      for (int i = 0; i < 6; i++) begin
        img[13 - i] = w[i];
      end
      for (int j = 0; j < 8; j++) begin
        img[7 - j] = w[6 + j];
      end
    end
    return img;
  endfunction : vbwssImage

  logic captionReady_q, captionReady_d;
  logic extendedReady_q, extendedReady_d;
  logic vbidWssReady_q, vbidWssReady_d;
  vdsr_armed_t armed_q, armed_d;
  logic [15:0] captionWord_q, captionWord_d;
  logic [15:0] extendedWord_q, extendedWord_d;
  logic [15:0] vbwssWord_q, vbwssWord_d;
  logic [7:0] regRdData_q, regRdData_d;
  logic reqWrite;
  logic capTake, extTake, vbTake;
  logic [7:0] statusByte;

  assign reqWrite = regWrEn && (regAddr == ADDR_REQUEST);
  // A completion only counts while that decoder is armed
  assign capTake = decodeDone.captionDone && armed_q.caption;
  assign extTake = decodeDone.extendedDone && armed_q.extended;
  assign vbTake = decodeDone.vbidWssDone && armed_q.vbidWss;

  assign statusByte = {vbidWssReady_q, extendedReady_q, captionReady_q,
                       videoStatus.gainMethodFlag, videoStatus.verticalLockFail,
                       videoStatus.inputOverflowFlag, videoStatus.chromaSuppressActive,
                       videoStatus.noInputFlag};

  // Decode handshake: set beats the clear so a result is never lost
  always_comb begin
    captionReady_d = captionReady_q;
    extendedReady_d = extendedReady_q;
    vbidWssReady_d = vbidWssReady_q;
    armed_d = armed_q;
    captionWord_d = captionWord_q;
    extendedWord_d = extendedWord_q;
    vbwssWord_d = vbwssWord_q;
    if (capTake) begin
      armed_d.caption = 1'b0;
    end
    if (extTake) begin
      armed_d.extended = 1'b0;
    end
    if (vbTake) begin
      armed_d.vbidWss = 1'b0;
    end
    if (reqWrite && regWrData[REQ_CAPTION_BIT]) begin
      captionReady_d = 1'b0;
      armed_d.caption = 1'b1;
    end
    if (reqWrite && regWrData[REQ_EXTENDED_BIT]) begin
      extendedReady_d = 1'b0;
      armed_d.extended = 1'b1;
    end
    if (reqWrite && regWrData[REQ_VBWSS_BIT]) begin
      vbidWssReady_d = 1'b0;
      armed_d.vbidWss = 1'b1;
    end
    if (capTake) begin
      captionReady_d = 1'b1;
      captionWord_d = decodeDone.captionWord;
    end
    if (extTake) begin
      extendedReady_d = 1'b1;
      extendedWord_d = decodeDone.extendedWord;
    end
    if (vbTake) begin
      vbidWssReady_d = 1'b1;
      vbwssWord_d = vbwssImage(decodeDone.wssMode, decodeDone.vbidWssWord);
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      captionReady_q <= 1'b0;
      extendedReady_q <= 1'b0;
      vbidWssReady_q <= 1'b0;
      armed_q <= '0;
      captionWord_q <= WORD_RESET;
      extendedWord_q <= WORD_RESET;
      vbwssWord_q <= WORD_RESET;
    end else begin
      captionReady_q <= captionReady_d;
      extendedReady_q <= extendedReady_d;
      vbidWssReady_q <= vbidWssReady_d;
      armed_q <= armed_d;
      captionWord_q <= captionWord_d;
      extendedWord_q <= extendedWord_d;
      vbwssWord_q <= vbwssWord_d;
    end
  end

  // Read path; status is sampled at the read strobe, so one cycle of latency
  always_comb begin
    regRdData_d = regRdData_q;
    if (regRdEn) begin
      unique case (regAddr)
        ADDR_STATUS: regRdData_d = statusByte;
        ADDR_COPY: regRdData_d = {1'b0, copyStatus};
        ADDR_CAPTION_LOW: regRdData_d = captionWord_q[7:0];
        ADDR_CAPTION_HIGH: regRdData_d = captionWord_q[15:8];
        ADDR_EXTENDED_LOW: regRdData_d = extendedWord_q[7:0];
        ADDR_EXTENDED_HIGH: regRdData_d = extendedWord_q[15:8];
        ADDR_VBWSS_ONE: regRdData_d = {2'b00, vbwssWord_q[13:8]};
        ADDR_VBWSS_TWO: regRdData_d = vbwssWord_q[7:0];
        ADDR_PART: regRdData_d = {REVISION_NUMBER, PART_CODE};
        default: regRdData_d = UNMAPPED_READ;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      regRdData_q <= READ_RESET;
    end else begin
      regRdData_q <= regRdData_d;
    end
  end

  assign regRdData = regRdData_q;
  assign decodeArmed = armed_q;

  caption_clear_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (reqWrite && regWrData[REQ_CAPTION_BIT] && !capTake) |=> (!captionReady_q && armed_q.caption))
    else $error("caption request did not clear and arm");

  caption_set_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    capTake |=> (captionReady_q && captionWord_q == $past(decodeDone.captionWord)))
    else $error("caption completion not stored");

  unarmed_ignore_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (decodeDone.extendedDone && !armed_q.extended && !reqWrite) |=> $stable(extendedWord_q) && $stable(extendedReady_q))
    else $error("extended data changed without request");

  vbwss_set_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (vbTake && decodeDone.wssMode) |=> (vbidWssReady_q && vbwssWord_q[13:0] == $past(decodeDone.vbidWssWord)))
    else $error("WSS result misplaced");

  status_read_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (regRdEn && regAddr == ADDR_STATUS) |=> (regRdData[0] == $past(videoStatus.noInputFlag)
      && regRdData[4] == $past(videoStatus.gainMethodFlag) && regRdData[5] == $past(captionReady_q)))
    else $error("status read mismatch");

  copy_read_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (regRdEn && regAddr == ADDR_COPY) |=> (regRdData == {1'b0, $past(copyStatus)}))
    else $error("protection read mismatch");

  vbid_read_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (regRdEn && regAddr == ADDR_VBWSS_ONE) |=> (regRdData[7:6] == 2'b00))
    else $error("reserved VBID bits not zero");

  part_read_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (regRdEn && regAddr == ADDR_PART) |=> (regRdData == {REVISION_NUMBER, PART_CODE}))
    else $error("identity read mismatch");

  write_ignore_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (regWrEn && regAddr != ADDR_REQUEST && !capTake) |=> $stable(captionWord_q) && $stable(captionReady_q))
    else $error("write to read-only register had effect");

  // Handshake of the other two decoders
  extended_clear_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (reqWrite && regWrData[REQ_EXTENDED_BIT] && !extTake) |=> (!extendedReady_q && armed_q.extended))
    else $error("extended request did not clear and arm");

  vbwss_clear_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (reqWrite && regWrData[REQ_VBWSS_BIT] && !vbTake) |=> (!vbidWssReady_q && armed_q.vbidWss))
    else $error("VBID or WSS request did not clear and arm");

  extended_set_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    extTake |=> (extendedReady_q && extendedWord_q == $past(decodeDone.extendedWord)))
    else $error("extended completion not stored");

  vbid_set_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (vbTake && !decodeDone.wssMode) |=> (vbidWssReady_q && vbwssWord_q[15:14] == 2'b00
      && vbwssWord_q[13] == $past(decodeDone.vbidWssWord[0])
      && vbwssWord_q[8] == $past(decodeDone.vbidWssWord[5])
      && vbwssWord_q[7] == $past(decodeDone.vbidWssWord[6])
      && vbwssWord_q[0] == $past(decodeDone.vbidWssWord[13])))
    else $error("VBID result misplaced");

  // A request landing with a completion must not lose the result
  set_wins_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (capTake && reqWrite && regWrData[REQ_CAPTION_BIT]) |=> (captionReady_q && armed_q.caption))
    else $error("caption result lost to a request");

  caption_drop_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (capTake && !reqWrite) |=> !armed_q.caption)
    else $error("caption decoder still armed after completion");

  extended_drop_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (extTake && !reqWrite) |=> !armed_q.extended)
    else $error("extended decoder still armed after completion");

  vbwss_drop_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (vbTake && !reqWrite) |=> !armed_q.vbidWss)
    else $error("VBID or WSS decoder still armed after completion");

  arm_only_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (!reqWrite && !armed_q.extended) |=> !armed_q.extended)
    else $error("extended decoder armed without request");

  caption_ignore_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (decodeDone.captionDone && !armed_q.caption && !reqWrite)
      |=> $stable(captionWord_q) && $stable(captionReady_q))
    else $error("caption data changed without request");

  vbwss_ignore_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (decodeDone.vbidWssDone && !armed_q.vbidWss && !reqWrite)
      |=> $stable(vbwssWord_q) && $stable(vbidWssReady_q))
    else $error("VBID or WSS data changed without request");

  status_rest_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (regRdEn && regAddr == ADDR_STATUS) |=> (regRdData[1] == $past(videoStatus.chromaSuppressActive)
      && regRdData[2] == $past(videoStatus.inputOverflowFlag) && regRdData[3] == $past(videoStatus.verticalLockFail)))
    else $error("status level bits mismatch");

  status_flags_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (regRdEn && regAddr == ADDR_STATUS) |=> (regRdData[6] == $past(extendedReady_q)
      && regRdData[7] == $past(vbidWssReady_q)))
    else $error("status ready flags mismatch");

  caption_low_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (regRdEn && regAddr == ADDR_CAPTION_LOW) |=> (regRdData == $past(captionWord_q[7:0])))
    else $error("caption low byte mismatch");

  caption_high_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (regRdEn && regAddr == ADDR_CAPTION_HIGH) |=> (regRdData == $past(captionWord_q[15:8])))
    else $error("caption high byte mismatch");

  extended_low_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (regRdEn && regAddr == ADDR_EXTENDED_LOW) |=> (regRdData == $past(extendedWord_q[7:0])))
    else $error("extended low byte mismatch");

  extended_high_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (regRdEn && regAddr == ADDR_EXTENDED_HIGH) |=> (regRdData == $past(extendedWord_q[15:8])))
    else $error("extended high byte mismatch");

  vbwss_one_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (regRdEn && regAddr == ADDR_VBWSS_ONE) |=> (regRdData[5:0] == $past(vbwssWord_q[13:8])))
    else $error("VBID or WSS first byte mismatch");

  vbwss_two_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (regRdEn && regAddr == ADDR_VBWSS_TWO) |=> (regRdData == $past(vbwssWord_q[7:0])))
    else $error("VBID or WSS second byte mismatch");

  request_read_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (regRdEn && regAddr == ADDR_REQUEST) |=> (regRdData == UNMAPPED_READ))
    else $error("request register did not read zero");

  write_hold_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (regWrEn && !regRdEn) |=> $stable(regRdData))
    else $error("write disturbed read data");

  extended_write_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (regWrEn && regAddr != ADDR_REQUEST && !extTake) |=> $stable(extendedWord_q) && $stable(extendedReady_q))
    else $error("write changed extended data");

endmodule : vdsr_status_regs

// [dv/vdsr_decoder_model.sv]
// Far-side decoder model that completes a decode some cycles after arming
`timescale 1ns/10ps
module vdsr_decoder_model
  import vdsr_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire vdsr_armed_t decodeArmed,
  input wire logic [3:0] delayCycles,
  input wire logic strayPulse,
  input wire logic wssMode,
  input wire logic [45:0] words,
  output vdsr_done_t decodeDone
);
  logic [3:0] waitCnt;
  logic [2:0] pulse;
  logic [2:0] armedRev;
  assign armedRev = {decodeArmed.caption, decodeArmed.extended, decodeArmed.vbidWss};
  // Words inverted outside a pulse, so stale data never looks valid
  assign decodeDone = {pulse, wssMode, (|pulse) ? words : ~words};
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      waitCnt <= 4'h0;
      pulse <= 3'h0;
    end else begin
      pulse <= {3{strayPulse}} | ((waitCnt == delayCycles) ? armedRev : 3'h0);
      waitCnt <= (armedRev != 3'h0 && waitCnt != delayCycles) ? waitCnt + 4'h1 : 4'h0;
    end
  end
endmodule : vdsr_decoder_model

// [dv/vdsr_status_regs_tb.sv]
// Self-checking bench for the video decoder status register bank
`timescale 1ns/10ps
module vdsr_status_regs_tb;
  import vdsr_pkg::*;
  localparam logic [5:0] PART = 6'h2a; // Arbitrary value
  localparam logic [1:0] REV = 2'h2; // Arbitrary value
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] regAddr = 8'h00;
  logic regWrEn = 1'b0;
  logic [7:0] regWrData = 8'h00;
  logic regRdEn = 1'b0;
  logic [7:0] regRdData;
  vdsr_video_t videoStatus = '0;
  vdsr_copy_t copyStatus = '0;
  vdsr_done_t decodeDone;
  vdsr_armed_t decodeArmed;
  logic [3:0] delayCycles = 4'h3;
  logic strayPulse = 1'b0;
  logic wssMode = 1'b0;
  logic [45:0] words = '0;
  logic [15:0] rnd = 16'haf54;
  int failures = 0;
  int compares = 0;
  logic [2:0] mReady;
  logic [2:0] mArmed;
  logic [15:0] mWord [3];
  logic mWss;
  wire [2:0] doneBits = {decodeDone.vbidWssDone, decodeDone.extendedDone, decodeDone.captionDone};
  always #4 clk_sys = ~clk_sys;
  vdsr_status_regs #(.PART_CODE(PART), .REVISION_NUMBER(REV)) i_vdsr_status_regs (.clk_sys(clk_sys),
    .reset_n(reset_n), .regAddr(regAddr), .regWrEn(regWrEn), .regWrData(regWrData), .regRdEn(regRdEn),
    .regRdData(regRdData), .videoStatus(videoStatus), .copyStatus(copyStatus), .decodeDone(decodeDone),
    .decodeArmed(decodeArmed));
  vdsr_decoder_model i_vdsr_decoder_model (.clk_sys(clk_sys), .reset_n(reset_n), .decodeArmed(decodeArmed),
    .delayCycles(delayCycles), .strayPulse(strayPulse), .wssMode(wssMode), .words(words),
    .decodeDone(decodeDone));
  // Reference model; request clears first, accepted completion then sets
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      mReady = 3'h0;
      mArmed = 3'h0;
      mWord = '{default: 16'h0000};
      mWss = 1'b0;
    end else begin
      for (int i = 0; i < 3; i++) begin
        if (regWrEn && regAddr == ADDR_REQUEST && regWrData[i]) mReady[i] = 1'b0;
        if (doneBits[i] && mArmed[i]) begin
          mReady[i] = 1'b1;
          mArmed[i] = 1'b0;
          mWord[i] = (i == 0) ? decodeDone.captionWord : (i == 1) ? decodeDone.extendedWord :
            {2'b00, decodeDone.vbidWssWord};
          if (i == 2) mWss = decodeDone.wssMode;
        end
        if (regWrEn && regAddr == ADDR_REQUEST && regWrData[i]) mArmed[i] = 1'b1;
      end
    end
  end
  function automatic logic [7:0] expect_byte(input logic [7:0] a);
    logic [13:0] w;
    logic [13:0] r;
    w = mWord[2][13:0];
    for (int k = 0; k < 14; k++) r[k] = w[13 - k];
    case (a)
      ADDR_STATUS: return {mReady, videoStatus};
      ADDR_COPY: return {1'b0, copyStatus};
      ADDR_CAPTION_LOW: return mWord[0][7:0];
      ADDR_CAPTION_HIGH: return mWord[0][15:8];
      ADDR_EXTENDED_LOW: return mWord[1][7:0];
      ADDR_EXTENDED_HIGH: return mWord[1][15:8];
      ADDR_VBWSS_ONE: return mWss ? {2'b00, w[13:8]} : {2'b00, r[13:8]};
      ADDR_VBWSS_TWO: return mWss ? w[7:0] : r[7:0];
      ADDR_PART: return {REV, PART};
      default: return 8'h00;
    endcase
  endfunction : expect_byte
  function automatic logic [15:0] lfsr(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction : lfsr
  task automatic check(input logic [7:0] seen, input logic [7:0] e);
    compares++;
    if (seen !== e) begin
      failures++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, e);
    end
  endtask : check
  task automatic rd(input logic [7:0] a);
    logic [7:0] e;
    regAddr = a;
    regRdEn = 1'b1;
    e = expect_byte(a);
    @(negedge clk_sys);
    regRdEn = 1'b0;
    @(negedge clk_sys);
    check(regRdData, e);
    check({5'h00, decodeArmed}, {5'h00, mArmed});
  endtask : rd
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    regAddr = a;
    regWrData = d;
    regWrEn = 1'b1;
    @(negedge clk_sys);
    regWrEn = 1'b0;
    @(negedge clk_sys);
  endtask : wr
  task automatic print_verdict();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : print_verdict
  initial begin
    #400000;
    failures++;
    print_verdict();
  end
  initial begin
    repeat (4) @(negedge clk_sys);
    reset_n = 1'b1;
    for (int a = 8; a < 26; a++) rd(8'(a));
    for (int a = 16; a < 26; a++) wr(8'(a), 8'hff);
    for (int a = 8; a < 26; a++) rd(8'(a));
    $display("test reset and read-only done");
    for (int n = 0; n < 40; n++) begin
      rnd = lfsr(rnd);
      videoStatus = rnd[4:0];
      copyStatus = rnd[15:9];
      delayCycles = rnd[8:5];
      rnd = lfsr(rnd);
      words = {rnd, ~rnd, rnd[13:0] ^ 14'h2a5a};
      wssMode = rnd[3];
      strayPulse = rnd[4];
      if (rnd[5]) wr(ADDR_REQUEST, rnd[15:8]);
      else @(negedge clk_sys);
      strayPulse = 1'b0;
      if (rnd[5] && rnd[6]) begin
        repeat (delayCycles) @(negedge clk_sys);
        wr(ADDR_REQUEST, rnd[15:8]);
      end
      repeat (rnd[11:8]) @(negedge clk_sys);
      if (n == 20) begin
        reset_n = 1'b0;
        @(negedge clk_sys);
        reset_n = 1'b1;
      end
      for (int a = 8; a < 26; a++) rd(8'(a));
    end
    $display("test random decode traffic done");
    print_verdict();
  end
endmodule : vdsr_status_regs_tb
